// ==== design/elie_ctrl.sv ====
// Notes on behaviour
// - twenty independent edge lines, each can raise an interrupt or event request.
// - each line picks rising, falling or both edges as its trigger.
// - each line has its own interrupt mask and event mask; an edge masked in one still raises the other request.
// - a pending bit per line records interrupt requests and is visible outside.
// - pulses shorter than a clock period are caught asynchronously, then synchronised.
// - sixteen lines choose their source pin from five ports, eighty pins in all.
module elie_ctrl
    import elie_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // pin side
    input wire elie_pins_t port_pins_i,
    input wire logic [NUM_INT_LINES-1:0] int_lines_i,
    // configuration
    input wire elie_cfg_t cfg_i,
    input wire elie_sel_t pin_sel_i,
    input wire logic [NUM_LINES-1:0] pend_clr_i,
    // requests toward the processor
    output logic [NUM_LINES-1:0] pending_o,
    output logic [NUM_LINES-1:0] event_o
);

    // port number above the last port selects no pin, line reads low
    function automatic logic pick_pin(input elie_pins_t pins, input logic [SEL_W-1:0] sel,
                                      input int unsigned idx);
        logic v;
        v = 1'h0;
        for (int unsigned p = 0; p < NUM_PORTS; p++) begin
            if (sel == SEL_W'(p)) begin
                v = pins[p][idx];
            end
        end
        return v;
    endfunction : pick_pin

    logic [NUM_LINES-1:0] line_src;
    logic [NUM_LINES-1:0] rise_det;
    logic [NUM_LINES-1:0] fall_det;
    logic [NUM_LINES-1:0] edge_det;
    logic [NUM_LINES-1:0] pend_set;
    logic [NUM_LINES-1:0] nxt_pending;
    logic [NUM_LINES-1:0] nxt_event;

    // changing a selection can itself look like an edge; clear pending afterwards
    genvar g;
    generate
        for (g = 0; g < NUM_LINES; g++) begin : g_line
            if (g < NUM_PIN_LINES) begin : g_pin
                assign line_src[g] = pick_pin(port_pins_i, pin_sel_i[g], g);
            end else begin : g_int
                assign line_src[g] = int_lines_i[g-NUM_PIN_LINES];
            end
            elie_edge_capture u_cap (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .line_i(line_src[g]),
                .rise_o(rise_det[g]),
                .fall_o(fall_det[g])
            );
        end
    endgenerate

    assign edge_det = (rise_det & cfg_i.rise_en) | (fall_det & cfg_i.fall_en);
    assign pend_set = edge_det & cfg_i.irq_mask;
    // a new edge in the clearing cycle wins
    assign nxt_pending = (pending_o & ~pend_clr_i) | pend_set;
    assign nxt_event = edge_det & cfg_i.evt_mask;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pending_o <= PEND_RST;
        end else begin
            pending_o <= nxt_pending;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            event_o <= EVT_RST;
        end else begin
            event_o <= nxt_event;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_pend_set: assert property (
        |pend_set |=> ((pending_o & $past(pend_set)) == $past(pend_set)))
        else $error("detected unmasked edge did not set pending");

    a_pend_hold: assert property (
        |(pending_o & ~pend_clr_i) |=>
        ((pending_o & $past(pending_o & ~pend_clr_i)) == $past(pending_o & ~pend_clr_i)))
        else $error("pending bit dropped without a clear");

    a_pend_clear: assert property (
        |(pend_clr_i & ~pend_set) |=> ((pending_o & $past(pend_clr_i & ~pend_set)) == '0))
        else $error("pending bit survived its clear");

    a_mask_block: assert property (
        ##1 ((pending_o & ~$past(pending_o) & ~$past(cfg_i.irq_mask)) == '0))
        else $error("masked line set its pending bit");

    // a bit already pending cannot rise again, so leave it out of both sides
    a_trig_sel: assert property (
        ##1 ((pending_o & ~$past(pending_o)) ==
             ($past(((rise_det & cfg_i.rise_en) | (fall_det & cfg_i.fall_en)) & cfg_i.irq_mask)
              & ~$past(pending_o))))
        else $error("pending rose without its selected edge");

    a_set_wins: assert property (
        |(pend_set & pend_clr_i) |=>
        ((pending_o & $past(pend_set & pend_clr_i)) == $past(pend_set & pend_clr_i)))
        else $error("clear beat a set in the same cycle");

    a_evt_masked: assert property (
        ##1 ((event_o & ~$past(cfg_i.evt_mask)) == '0))
        else $error("masked line raised an event");

    a_no_trigger: assert property (
        ##1 ((event_o & ~$past(cfg_i.rise_en | cfg_i.fall_en)) == '0))
        else $error("event without any trigger selected");

    a_evt_pulse: assert property (
        ##1 (event_o == $past(edge_det & cfg_i.evt_mask)))
        else $error("event output does not follow masked edge");

    a_pin_route: assert property (
        (pin_sel_i[0] == 3'h0) |-> (line_src[0] == port_pins_i[0][0]))
        else $error("line zero not routed from selected port");

    a_src_none: assert property (
        (pin_sel_i[1] > 3'h4) |-> (line_src[1] == 1'h0))
        else $error("unused selection did not read low");

    c_pend_set: cover property (|pend_set ##1 |pending_o);
    c_set_clear: cover property (|(pend_set & pend_clr_i));
    c_event: cover property (|event_o);
    c_both_edges: cover property (|(rise_det & fall_det & cfg_i.rise_en & cfg_i.fall_en));

endmodule : elie_ctrl

// ==== design/elie_edge_capture.sv ====
module elie_edge_capture
    import elie_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // line from outside the clock domain
    input wire logic line_i,
    // one-cycle edge pulses on clk_i
    output logic rise_o,
    output logic fall_o
);

    logic rise_tog_ff;
    logic fall_tog_ff;
    logic [2:0] rise_sync_ff;
    logic [2:0] fall_sync_ff;
    logic rise_seen_ff;
    logic fall_seen_ff;

    // line itself clocks the toggles, so pulses shorter than clk_i are kept
    always_ff @(posedge line_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rise_tog_ff <= TOG_RST;
        end else begin
            rise_tog_ff <= ~rise_tog_ff;
        end
    end

    always_ff @(negedge line_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fall_tog_ff <= TOG_RST;
        end else begin
            fall_tog_ff <= ~fall_tog_ff;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rise_sync_ff <= {3{TOG_RST}};
            fall_sync_ff <= {3{TOG_RST}};
        end else begin
            rise_sync_ff <= {rise_sync_ff[1:0], rise_tog_ff};
            fall_sync_ff <= {fall_sync_ff[1:0], fall_tog_ff};
        end
    end

    // a toggle counts only when stages two and three agree
    logic nxt_rise;
    logic nxt_fall;
    assign nxt_rise = (rise_sync_ff[1] == rise_sync_ff[2]) && (rise_sync_ff[2] != rise_seen_ff);
    assign nxt_fall = (fall_sync_ff[1] == fall_sync_ff[2]) && (fall_sync_ff[2] != fall_seen_ff);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rise_seen_ff <= TOG_RST;
            fall_seen_ff <= TOG_RST;
            rise_o <= 1'h0;
            fall_o <= 1'h0;
        end else begin
            if (nxt_rise) begin
                rise_seen_ff <= rise_sync_ff[2];
            end
            if (nxt_fall) begin
                fall_seen_ff <= fall_sync_ff[2];
            end
            rise_o <= nxt_rise;
            fall_o <= nxt_fall;
        end
    end

    a_rise_single: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rise_o |=> !rise_o)
        else $error("rise pulse lasted more than one cycle");

    a_fall_cause: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        fall_o |-> $past(fall_sync_ff[2]) != $past(fall_seen_ff))
        else $error("fall pulse without a synchronised toggle");

endmodule : elie_edge_capture

// ==== design/elie_pkg.sv ====
package elie_pkg;

    localparam int unsigned NUM_LINES = 20;
    localparam int unsigned NUM_PIN_LINES = 16;
    localparam int unsigned NUM_PORTS = 5;
    localparam int unsigned SEL_W = 3;
    localparam int unsigned NUM_INT_LINES = NUM_LINES - NUM_PIN_LINES;

    localparam logic [NUM_LINES-1:0] PEND_RST = 20'h00000;
    localparam logic [NUM_LINES-1:0] EVT_RST = 20'h00000;
    localparam logic TOG_RST = 1'h0;

    // per-line configuration, one bit per line in each field
    typedef struct packed {
        logic [NUM_LINES-1:0] rise_en;
        logic [NUM_LINES-1:0] fall_en;
        logic [NUM_LINES-1:0] irq_mask;
        logic [NUM_LINES-1:0] evt_mask;
    } elie_cfg_t;

    typedef logic [NUM_PIN_LINES-1:0][SEL_W-1:0] elie_sel_t;
    typedef logic [NUM_PORTS-1:0][NUM_PIN_LINES-1:0] elie_pins_t;

endpackage : elie_pkg

// ==== test/edge_line_interrupt_event_ctrl_tb.sv ====
module edge_line_interrupt_event_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import elie_pkg::*;
    localparam logic [NUM_LINES-1:0] ALL = 20'hFFFFF;
    logic clk_i = 1'h0;
    logic rst_n_i = 1'h1;
    elie_pins_t pins;
    logic [NUM_INT_LINES-1:0] ints;
    elie_cfg_t cfg_i = '0;
    elie_sel_t pin_sel_i = '0;
    logic [NUM_LINES-1:0] pend_clr_i = '0;
    logic [NUM_LINES-1:0] pending_o;
    logic [NUM_LINES-1:0] event_o;
    int error_cnt = 0;
    int checks = 0;

    always #10 clk_i = ~clk_i;

    elie_pin_model elie_pin_model_i (.port_pins_o(pins), .int_lines_o(ints));
    elie_ctrl elie_ctrl_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .port_pins_i(pins),
        .int_lines_i(ints), .cfg_i(cfg_i), .pin_sel_i(pin_sel_i), .pend_clr_i(pend_clr_i),
        .pending_o(pending_o), .event_o(event_o));

    task automatic chk(input string what, input logic [NUM_LINES-1:0] exp,
                       input logic [NUM_LINES-1:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out

    task automatic step();
        @(posedge clk_i);
        #2;
    endtask : step

    task automatic setup(input logic [NUM_LINES-1:0] r, f, im, em);
        cfg_i = {r, f, im, em};
        pend_clr_i = ALL;
        step();
        pend_clr_i = '0;
    endtask : setup

    // window covers the longest pulse plus the sync latency
    task automatic fire(input int unsigned prt, pin, w, ln, input logic [NUM_LINES-1:0] exp_p,
                        input int exp_n);
        int n;
        n = 0;
        fork
            elie_pin_model_i.pulse(prt, pin, w);
            repeat (16) begin
                step();
                if (event_o[ln] === 1'b1) n++;
            end
        join
        chk("pending_o", exp_p, pending_o);
        chk("event count", 20'(exp_n), 20'(n));
    endtask : fire

    // modes 1..3 wide, then rise and fall only with a 5 ns glitch
    task automatic t_edges();
        for (int m = 1; m < 6; m++) begin
            setup((m % 3) != 2 ? ALL : '0, (m % 3) != 1 ? ALL : '0, ALL, ALL);
            fire(0, 3, m > 3 ? 5 : 200, 3, 20'h00008, m == 3 ? 2 : 1);
        end
        $display("t_edges done");
    endtask : t_edges

    task automatic t_mask();
        setup(ALL, '0, ~20'h00008, ALL);
        fire(0, 3, 5, 3, 20'h00000, 1);
        setup(ALL, '0, ALL, ~20'h00008);
        fire(0, 3, 5, 3, 20'h00008, 0);
        $display("t_mask done");
    endtask : t_mask

    task automatic t_clear();
        setup(ALL, '0, ALL, ALL);
        fire(0, 3, 5, 3, 20'h00008, 1);
        pend_clr_i = 20'h00010;
        step();
        pend_clr_i = '0;
        chk("pending_o", 20'h00008, pending_o);
        pend_clr_i = 20'h00008;
        step();
        pend_clr_i = '0;
        chk("pending_o", 20'h00000, pending_o);
        $display("t_clear done");
    endtask : t_clear

    task automatic t_select();
        setup(ALL, '0, ALL, ALL);
        pin_sel_i[7] = 3'h4;
        fire(0, 7, 5, 7, 20'h00000, 0);
        fire(4, 7, 5, 7, 20'h00080, 1);
        pin_sel_i[7] = 3'h5;
        fire(4, 7, 5, 7, 20'h00080, 0);
        fire(NUM_PORTS, 2, 5, 18, 20'h40080, 1);
        $display("t_select done");
    endtask : t_select

    // a real falling edge so toggles clocked by the lines see their reset
    initial begin
        #1;
        rst_n_i = 1'h0;
        repeat (10) @(posedge clk_i);
        #2;
        chk("pending_o", 20'h00000, pending_o);
        rst_n_i = 1'h1;
        step();
        t_edges();
        t_mask();
        t_clear();
        t_select();
        close_out();
    end

    // tests take well under 1000 cycles
    initial begin
        #50000;
        error_cnt++;
        close_out();
    end
endmodule : edge_line_interrupt_event_ctrl_tb

// ==== test/elie_pin_model.sv ====
module elie_pin_model
    import elie_pkg::*;
(
    // pin levels toward the controller
    output elie_pins_t port_pins_o,
    output logic [NUM_INT_LINES-1:0] int_lines_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle low, every pulse returns to idle
    initial begin
        port_pins_o = '0;
        int_lines_o = '0;
    end

    // prt equal to the port count selects the internal lines
    task automatic pulse(input int unsigned prt, input int unsigned pin, input int unsigned w);
        for (int k = 0; k < 2; k++) begin
            if (prt < NUM_PORTS) port_pins_o[prt][pin] = ~port_pins_o[prt][pin];
            else int_lines_o[pin] = ~int_lines_o[pin];
            if (k == 0) #(w);
        end
    endtask : pulse
endmodule : elie_pin_model
